//--- dsl_pkg.sv
`default_nettype none
package dsl_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0C;
  localparam logic [7:0] OFF_LEDS = 8'h10;

  localparam int EV_W = 6;
  localparam int EV_RIO_ERR = 0;
  localparam int EV_CARRIER = 1;
  localparam int EV_SER_LINK = 2;
  localparam int EV_SER_INT = 3;
  localparam int EV_RIO_FAIL = 4;
  localparam int EV_SER_FAIL = 5;
  localparam logic [5:0] STATUS_RST = 6'h00;
  localparam logic [5:0] MASK_RST = 6'h00;

  localparam int CTRL_W = 2;
  localparam int CTRL_LAMP = 0;
  localparam int CTRL_SER_OFF = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  localparam int SW_W = 8;
  localparam int DROP_SW_W = 5;
  localparam int SER_DTR_BOT = 0;
  localparam int SER_DTR_TOP = 1;
  localparam int SER_ADDR_LSB = 2;
  localparam int SER_ADDR_W = 4;
  localparam int SER_CONF = 6;

  localparam int ADDR_W = 6;
  localparam logic [5:0] DROP_ADDR_OFS = 6'h01;
  localparam logic [5:0] PORT_LO_OFS = 6'h01;
  localparam logic [5:0] PORT_HI_OFS = 6'h02;
  localparam logic [5:0] ADDR_RST = 6'h00;

  localparam int CFG_DROP_LSB = 0;
  localparam int CFG_PLO_LSB = 8;
  localparam int CFG_PHI_LSB = 16;
  localparam int CFG_DTR_BOT = 24;
  localparam int CFG_DTR_TOP = 25;
  localparam int CFG_CONF = 26;
  localparam int CFG_CAPT = 27;

  localparam int CODE_W = 3;
  localparam logic [2:0] CODE_PASS = 3'h0;
  localparam int FC_ACT = 0;
  localparam int FC_ERR = 1;
  localparam int FC_IF = 2;
  localparam int LED_W = 8;
  localparam int LED_RIO_RDY = 0;
  localparam int LED_RIO_ACT = 1;
  localparam int LED_RIO_FLT = 2;
  localparam int LED_RIO_IF = 3;
  localparam int LED_SER_RDY = 4;
  localparam int LED_SER_ACT = 5;
  localparam int LED_SER_LNK = 6;
  localparam int LED_SER_INT = 7;

  typedef enum logic [0:0] {
    DSL_CAP_WAIT = 1'b0,
    DSL_CAP_HELD = 1'b1
  } dsl_cap_st_t;
endpackage
`default_nettype wire

//--- dsl_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dsl_cfg_if;
  logic [5:0] drop_addr;
  logic [5:0] port_lo;
  logic [5:0] port_hi;
  logic dtr_bottom;
  logic dtr_top;
  logic conf_test;
  logic captured;
  modport prod (output drop_addr, output port_lo, output port_hi, output dtr_bottom,
                output dtr_top, output conf_test, output captured);
  modport cons (input drop_addr, input port_lo, input port_hi, input dtr_bottom,
                input dtr_top, input conf_test, input captured);
endinterface
`default_nettype wire

//--- dsl_flash.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_flash #(
  parameter int HALF_CYC = dsl_pkg::FLASH_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic blink
);
  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  if (HALF_CYC < 1) begin : g_chk
    $error("dsl_flash: HALF_CYC must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic blink_q;
  wire wrap = (cnt_q == LAST);

  assign cnt_d = wrap ? '0 : cnt_q + CW'(1);
  assign blink = blink_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      blink_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (wrap) begin
        blink_q <= ~blink_q;
      end
    end
  end
endmodule // dsl_flash
`default_nettype wire

//--- dsl_sw_capture.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_sw_capture (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] drop_sw,
  input wire logic [7:0] ser_sw,
  dsl_cfg_if.prod cfg
);
  dsl_pkg::dsl_cap_st_t st_q;
  logic [5:0] drop_q;
  logic [5:0] plo_q;
  logic [5:0] phi_q;
  logic dtr_bot_q;
  logic dtr_top_q;
  logic conf_q;

  wire [5:0] drop_bin = {1'b0, drop_sw[dsl_pkg::DROP_SW_W-1:0]};
  wire [5:0] pair_n2 = {1'b0, ser_sw[dsl_pkg::SER_ADDR_LSB +: dsl_pkg::SER_ADDR_W], 1'b0};
  wire [5:0] drop_d = drop_bin + dsl_pkg::DROP_ADDR_OFS;
  wire [5:0] plo_d = pair_n2 + dsl_pkg::PORT_LO_OFS;
  wire [5:0] phi_d = pair_n2 + dsl_pkg::PORT_HI_OFS;
  wire load = (st_q == dsl_pkg::DSL_CAP_WAIT);

  // capture once after reset release, then hold
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= dsl_pkg::DSL_CAP_WAIT;
      drop_q <= dsl_pkg::ADDR_RST;
      plo_q <= dsl_pkg::ADDR_RST;
      phi_q <= dsl_pkg::ADDR_RST;
      dtr_bot_q <= 1'b0;
      dtr_top_q <= 1'b0;
      conf_q <= 1'b0;
    end else if (load) begin
      st_q <= dsl_pkg::DSL_CAP_HELD;
      drop_q <= drop_d;
      plo_q <= plo_d;
      phi_q <= phi_d;
      dtr_bot_q <= ser_sw[dsl_pkg::SER_DTR_BOT];
      dtr_top_q <= ser_sw[dsl_pkg::SER_DTR_TOP];
      conf_q <= ser_sw[dsl_pkg::SER_CONF];
    end
  end

  assign cfg.drop_addr = drop_q;
  assign cfg.port_lo = plo_q;
  assign cfg.port_hi = phi_q;
  assign cfg.dtr_bottom = dtr_bot_q;
  assign cfg.dtr_top = dtr_top_q;
  assign cfg.conf_test = conf_q;
  assign cfg.captured = (st_q == dsl_pkg::DSL_CAP_HELD);
endmodule // dsl_sw_capture
`default_nettype wire

//--- dsl_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - drop address is switches 1-5 plus one
// - serial switch 1 sets bottom handshake
// - serial switch 2 sets top handshake
// - switches 3-6 give port pair 2n+1,2n+2
// - switch 7 runs confidence test, no comms
// - network ready lit after self test passes
// - network activity lit while data moves
// - network fault lit on link error
// - dual port missing carrier lights fault
// - serial ready lit after self test passes
// - serial activity lit while characters move
// - serial link fault on device error
// - serial internal fault on module error
// - self test failures shown as flash codes
module dsl_top #(
  parameter int FLASH_HALF_CYC = dsl_pkg::FLASH_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] drop_sw,
  input wire logic [7:0] ser_sw,
  input wire logic rio_test_done,
  input wire logic [2:0] rio_test_code,
  input wire logic rio_io_busy,
  input wire logic rio_comm_err,
  input wire logic dual_port,
  input wire logic [1:0] rio_carrier,
  input wire logic ser_test_done,
  input wire logic [2:0] ser_test_code,
  input wire logic ser_char_busy,
  input wire logic ser_link_err,
  input wire logic ser_int_err,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic rio_ready_led,
  output logic rio_activity_indicator,
  output logic rio_link_fault_indicator,
  output logic rio_if_fault_led,
  output logic ser_ready_led,
  output logic ser_activity_indicator,
  output logic ser_link_fault_indicator,
  output logic ser_int_fault_led,
  output logic [5:0] drop_addr,
  output logic [5:0] port_lo_addr,
  output logic [5:0] port_hi_addr,
  output logic dtr_bottom,
  output logic dtr_top,
  output logic conf_test,
  output logic ser_comm_en
);
  if (FLASH_HALF_CYC < 1) begin : g_chk
    $error("dsl_top: FLASH_HALF_CYC must be at least 1");
  end
  // refuse package settings that the decode cannot serve
  if (dsl_pkg::EV_W > dsl_pkg::DW) begin : g_chk_ev
    $error("dsl_top: event field wider than the data word");
  end
  if (dsl_pkg::LED_SER_INT >= dsl_pkg::LED_W) begin : g_chk_led
    $error("dsl_top: indicator position outside the lamp word");
  end
  if (dsl_pkg::CFG_CAPT >= dsl_pkg::DW) begin : g_chk_cfg
    $error("dsl_top: config word does not fit the data word");
  end
  if (dsl_pkg::FC_IF >= dsl_pkg::CODE_W) begin : g_chk_code
    $error("dsl_top: flash code bit outside the test code");
  end
  if (dsl_pkg::SER_CONF >= dsl_pkg::SW_W) begin : g_chk_sw
    $error("dsl_top: switch field outside the bank");
  end
  if (dsl_pkg::EV_SER_FAIL >= dsl_pkg::EV_W) begin : g_chk_evid
    $error("dsl_top: event index outside the status word");
  end
  if (dsl_pkg::CTRL_SER_OFF >= dsl_pkg::CTRL_W) begin : g_chk_ctrl
    $error("dsl_top: control bit outside the control word");
  end
  if (dsl_pkg::CFG_PLO_LSB < dsl_pkg::CFG_DROP_LSB + dsl_pkg::ADDR_W) begin : g_chk_fld
    $error("dsl_top: config address fields overlap");
  end

  dsl_cfg_if cfg_bus ();
  logic blink;

  dsl_sw_capture u_cap (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .drop_sw(drop_sw),
    .ser_sw(ser_sw),
    .cfg(cfg_bus.prod)
  );

  dsl_flash #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .blink(blink)
  );

  // register state
  logic [5:0] status_q;
  logic [5:0] status_d;
  logic [5:0] mask_q;
  logic [1:0] ctrl_q;
  logic [5:0] ev_prev_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic [7:0] led_q;
  logic [7:0] led_d;
  logic comm_en_q;

  // self test outcome
  wire rio_ok = rio_test_done & (rio_test_code == dsl_pkg::CODE_PASS);
  wire rio_fail = rio_test_done & (rio_test_code != dsl_pkg::CODE_PASS);
  wire ser_ok = ser_test_done & (ser_test_code == dsl_pkg::CODE_PASS);
  wire ser_fail = ser_test_done & (ser_test_code != dsl_pkg::CODE_PASS);

  // single port unit ignores both carriers
  wire carrier_loss = dual_port & ~(&rio_carrier);

  // network side indicators, flash code replaces normal display on failure
  wire rio_rdy_n = rio_ok;
  wire rio_act_n = rio_ok & rio_io_busy;
  wire rio_flt_n = rio_ok & (rio_comm_err | carrier_loss);
  wire rio_act_f = rio_fail & rio_test_code[dsl_pkg::FC_ACT] & blink;
  wire rio_flt_f = rio_fail & rio_test_code[dsl_pkg::FC_ERR] & blink;
  wire rio_if_f = rio_fail & rio_test_code[dsl_pkg::FC_IF] & blink;

  // serial side indicators
  wire ser_rdy_n = ser_ok;
  wire ser_act_n = ser_ok & ser_char_busy;
  wire ser_lnk_n = ser_ok & ser_link_err;
  wire ser_int_n = ser_ok & ser_int_err;
  wire ser_act_f = ser_fail & ser_test_code[dsl_pkg::FC_ACT] & blink;
  wire ser_lnk_f = ser_fail & ser_test_code[dsl_pkg::FC_ERR] & blink;
  wire ser_int_f = ser_fail & ser_test_code[dsl_pkg::FC_IF] & blink;

  always_comb begin
    led_d = 8'h00;
    led_d[dsl_pkg::LED_RIO_RDY] = rio_rdy_n;
    led_d[dsl_pkg::LED_RIO_ACT] = rio_act_n | rio_act_f;
    led_d[dsl_pkg::LED_RIO_FLT] = rio_flt_n | rio_flt_f;
    led_d[dsl_pkg::LED_RIO_IF] = rio_if_f;
    led_d[dsl_pkg::LED_SER_RDY] = ser_rdy_n;
    led_d[dsl_pkg::LED_SER_ACT] = ser_act_n | ser_act_f;
    led_d[dsl_pkg::LED_SER_LNK] = ser_lnk_n | ser_lnk_f;
    led_d[dsl_pkg::LED_SER_INT] = ser_int_n | ser_int_f;
  end

  // confidence test mode keeps the serial ports off line
  wire comm_en_d = cfg_bus.captured & ~cfg_bus.conf_test
                   & ~ctrl_q[dsl_pkg::CTRL_SER_OFF] & ser_ok;

  // events: rising edges of the fault conditions
  logic [5:0] ev_now;
  always_comb begin
    ev_now = 6'h00;
    ev_now[dsl_pkg::EV_RIO_ERR] = rio_comm_err;
    ev_now[dsl_pkg::EV_CARRIER] = carrier_loss;
    ev_now[dsl_pkg::EV_SER_LINK] = ser_link_err;
    ev_now[dsl_pkg::EV_SER_INT] = ser_int_err;
    ev_now[dsl_pkg::EV_RIO_FAIL] = rio_fail;
    ev_now[dsl_pkg::EV_SER_FAIL] = ser_fail;
  end
  wire [5:0] ev_rise = ev_now & ~ev_prev_q;

  // address decode
  wire sel_status = (reg_addr == dsl_pkg::OFF_STATUS);
  wire sel_mask = (reg_addr == dsl_pkg::OFF_MASK);
  wire sel_ctrl = (reg_addr == dsl_pkg::OFF_CTRL);
  wire sel_config = (reg_addr == dsl_pkg::OFF_CONFIG);
  wire sel_leds = (reg_addr == dsl_pkg::OFF_LEDS);
  wire wr_status = reg_wr & sel_status;
  wire wr_mask = reg_wr & sel_mask;
  wire wr_ctrl = reg_wr & sel_ctrl;
  wire [5:0] w1c = wr_status ? reg_wdata[dsl_pkg::EV_W-1:0] : 6'h00;

  // a new event beats a simultaneous clear
  assign status_d = (status_q & ~w1c) | ev_rise;

  logic [31:0] cfg_word;
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[dsl_pkg::CFG_DROP_LSB +: dsl_pkg::ADDR_W] = cfg_bus.drop_addr;
    cfg_word[dsl_pkg::CFG_PLO_LSB +: dsl_pkg::ADDR_W] = cfg_bus.port_lo;
    cfg_word[dsl_pkg::CFG_PHI_LSB +: dsl_pkg::ADDR_W] = cfg_bus.port_hi;
    cfg_word[dsl_pkg::CFG_DTR_BOT] = cfg_bus.dtr_bottom;
    cfg_word[dsl_pkg::CFG_DTR_TOP] = cfg_bus.dtr_top;
    cfg_word[dsl_pkg::CFG_CONF] = cfg_bus.conf_test;
    cfg_word[dsl_pkg::CFG_CAPT] = cfg_bus.captured;
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_status) begin
      rd_mux[dsl_pkg::EV_W-1:0] = status_q;
    end else if (sel_mask) begin
      rd_mux[dsl_pkg::EV_W-1:0] = mask_q;
    end else if (sel_ctrl) begin
      rd_mux[dsl_pkg::CTRL_W-1:0] = ctrl_q;
    end else if (sel_config) begin
      rd_mux = cfg_word;
    end else if (sel_leds) begin
      rd_mux[dsl_pkg::LED_W-1:0] = led_q;
    end
  end
  // read data stand one cycle only
  assign rdata_d = reg_rd ? rd_mux : 32'h0000_0000;

  // one sticky flag and one edge detector per event source
  for (genvar e = 0; e < dsl_pkg::EV_W; e++) begin : g_ev
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        status_q[e] <= dsl_pkg::STATUS_RST[e];
        ev_prev_q[e] <= 1'b0;
      end else begin
        status_q[e] <= status_d[e];
        ev_prev_q[e] <= ev_now[e];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask_q <= dsl_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_q <= reg_wdata[dsl_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= dsl_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[dsl_pkg::CTRL_W-1:0];
    end
  end

  // irq follows the next status value so it rises with the flag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      led_q <= 8'h00;
    end else begin
      led_q <= led_d;
    end
  end

  // serial ports stay off line until capture and a passed self test
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      comm_en_q <= 1'b0;
    end else begin
      comm_en_q <= comm_en_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign rio_ready_led = led_q[dsl_pkg::LED_RIO_RDY];
  assign rio_activity_indicator = led_q[dsl_pkg::LED_RIO_ACT];
  assign rio_link_fault_indicator = led_q[dsl_pkg::LED_RIO_FLT];
  assign rio_if_fault_led = led_q[dsl_pkg::LED_RIO_IF];
  assign ser_ready_led = led_q[dsl_pkg::LED_SER_RDY];
  assign ser_activity_indicator = led_q[dsl_pkg::LED_SER_ACT];
  assign ser_link_fault_indicator = led_q[dsl_pkg::LED_SER_LNK];
  assign ser_int_fault_led = led_q[dsl_pkg::LED_SER_INT];
  assign drop_addr = cfg_bus.drop_addr;
  assign port_lo_addr = cfg_bus.port_lo;
  assign port_hi_addr = cfg_bus.port_hi;
  assign dtr_bottom = cfg_bus.dtr_bottom;
  assign dtr_top = cfg_bus.dtr_top;
  assign conf_test = cfg_bus.conf_test;
  assign ser_comm_en = comm_en_q;
endmodule // dsl_top
`default_nettype wire

//--- dsl_head_end.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_head_end (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic go,
  input wire logic [3:0] len,
  output logic rio_io_busy
);
  logic [3:0] cnt_q;
  // one frame of io traffic lasting len cycles
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) cnt_q <= 4'h0;
    else if (go) cnt_q <= len;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign rio_io_busy = cnt_q != 4'h0;
endmodule // dsl_head_end
`default_nettype wire

//--- dsl_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_top_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] drop_sw,
  input wire logic [7:0] ser_sw,
  input wire logic rio_test_done,
  input wire logic [2:0] rio_test_code,
  input wire logic rio_io_busy,
  input wire logic rio_comm_err,
  input wire logic dual_port,
  input wire logic [1:0] rio_carrier,
  input wire logic ser_test_done,
  input wire logic [2:0] ser_test_code,
  input wire logic ser_char_busy,
  input wire logic ser_link_err,
  input wire logic ser_int_err,
  input wire logic rio_ready_led,
  input wire logic rio_activity_indicator,
  input wire logic rio_link_fault_indicator,
  input wire logic ser_ready_led,
  input wire logic ser_activity_indicator,
  input wire logic ser_link_fault_indicator,
  input wire logic ser_int_fault_led,
  input wire logic [5:0] drop_addr,
  input wire logic [5:0] port_lo_addr,
  input wire logic [5:0] port_hi_addr,
  input wire logic dtr_bottom,
  input wire logic dtr_top,
  input wire logic conf_test,
  input wire logic ser_comm_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire rp = rio_test_done && rio_test_code == dsl_pkg::CODE_PASS;
  wire sp = ser_test_done && ser_test_code == dsl_pkg::CODE_PASS;
  wire cl = dual_port && rio_carrier != 2'h3;
  property p_drop;
    $rose(rstn) |=> drop_addr == $past(drop_sw[4:0]) + 6'h01;
  endproperty
  a_drop: assert property (p_drop) else $error("drop address decode");
  property p_port;
    $rose(rstn) |=> port_lo_addr == {$past(ser_sw[5:2]), 1'b1} && port_hi_addr == {$past(ser_sw[5:2]), 1'b0} + 6'h02;
  endproperty
  a_port: assert property (p_port) else $error("port pair decode");
  property p_flags;
    $rose(rstn) |=> dtr_bottom == $past(ser_sw[0]) && dtr_top == $past(ser_sw[1]) && conf_test == $past(ser_sw[6]);
  endproperty
  a_flags: assert property (p_flags) else $error("handshake or test flag");
  property p_hold;
    $past(rstn) && $past(rstn, 2) |-> $stable(drop_addr) && $stable(port_hi_addr) && $stable(conf_test);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed after capture");
  property p_conf;
    conf_test |-> !ser_comm_en;
  endproperty
  a_conf: assert property (p_conf) else $error("comms during test mode");
  property p_rrdy;
    rio_ready_led |-> $past(rp);
  endproperty
  a_rrdy: assert property (p_rrdy) else $error("ready without pass");
  property p_ract;
    $past(rp) |-> rio_activity_indicator == $past(rio_io_busy);
  endproperty
  a_ract: assert property (p_ract) else $error("network activity");
  property p_rflt;
    $past(rp) |-> rio_link_fault_indicator == ($past(rio_comm_err) || $past(cl));
  endproperty
  a_rflt: assert property (p_rflt) else $error("network fault");
  property p_sled;
    $past(sp) |-> ser_ready_led && ser_activity_indicator == $past(ser_char_busy)
      && ser_link_fault_indicator == $past(ser_link_err) && ser_int_fault_led == $past(ser_int_err);
  endproperty
  a_sled: assert property (p_sled) else $error("serial indicators");
  property p_rfail;
    $past(rio_test_done) && $past(rio_test_code) != 3'h0 |-> !rio_ready_led;
  endproperty
  a_rfail: assert property (p_rfail) else $error("ready on failed test");
endmodule // dsl_top_chk
bind dsl_top dsl_top_chk dsl_top_chk_i (.*);
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, rstn, rio_test_done, rio_io_busy, rio_comm_err, dual_port, ser_test_done;
  logic ser_char_busy, ser_link_err, ser_int_err, reg_wr, reg_rd, go;
  logic [7:0] drop_sw, ser_sw, reg_addr;
  logic [2:0] rio_test_code, ser_test_code;
  logic [1:0] rio_carrier;
  logic [31:0] reg_wdata, reg_rdata, d, cfg;
  logic irq, rio_ready_led, rio_activity_indicator, rio_link_fault_indicator, rio_if_fault_led;
  logic ser_ready_led, ser_activity_indicator, ser_link_fault_indicator, ser_int_fault_led;
  logic [5:0] drop_addr, port_lo_addr, port_hi_addr;
  logic dtr_bottom, dtr_top, conf_test, ser_comm_en;
  int fails, checks;
  dsl_top #(.FLASH_HALF_CYC(4)) dsl_top_i (.*);
  dsl_head_end dsl_head_end_i (.clk_sys(clk_sys), .rstn(rstn), .go(go), .len(4'h5), .rio_io_busy(rio_io_busy));
  task chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr32(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd32(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task rst(input logic [7:0] ds, input logic [7:0] ss, input int n);
    @(posedge clk_sys);
    rstn <= 1'b0;
    rio_test_done <= 1'b0;
    ser_test_done <= 1'b0;
    rio_comm_err <= 1'b0;
    ser_link_err <= 1'b0;
    drop_sw <= ds;
    ser_sw <= ss;
    repeat (n) @(posedge clk_sys);
    rstn <= 1'b1;
  endtask
  task t_decode(input logic [4:0] a, input logic [3:0] n, input logic [2:0] f);
    logic [5:0] dr, lo;
    dr = 6'(a) + 6'h01;
    lo = {1'b0, n, 1'b1};
    cfg = {4'h0, 1'b1, f, 2'h0, lo + 6'h01, 2'h0, lo, 2'h0, dr};
    rst({3'h0, a}, {1'b0, f[2], n, f[1:0]}, 3);
    tk(2);
    chk(drop_addr === dr, "drop");
    chk(port_lo_addr === lo && port_hi_addr === lo + 6'h01, "port");
    chk({conf_test, dtr_top, dtr_bottom} === f, "flags");
    rd32(dsl_pkg::OFF_CONFIG);
    chk(d === cfg, "config");
    @(posedge clk_sys);
    drop_sw <= {3'h0, ~a};
    ser_sw <= {1'b0, ~f[2], ~n, ~f[1:0]};
    ser_test_done <= 1'b1;
    tk(3);
    chk(drop_addr === dr && port_hi_addr === lo + 6'h01 && dtr_top === f[1], "hold");
    chk(ser_comm_en === !f[2], "comm");
  endtask
  task t_leds;
    @(posedge clk_sys);
    rio_test_done <= 1'b1;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    tk(2);
    chk(rio_ready_led === 1'b1 && ser_ready_led === 1'b1, "ready");
    chk(rio_activity_indicator === 1'b1, "busy");
    tk(6);
    chk(rio_activity_indicator === 1'b0, "idle");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      rio_comm_err <= i == 0;
      dual_port <= i == 1;
      ser_link_err <= i == 2;
      ser_int_err <= i == 3;
      ser_char_busy <= i == 3;
      tk(2);
      chk({rio_link_fault_indicator, ser_link_fault_indicator, ser_int_fault_led} === {i < 2, i == 2, i == 3}, "fault");
      chk(ser_activity_indicator === (i == 3) && rio_ready_led === 1'b1, "act");
    end
  endtask
  task t_irq;
    @(posedge clk_sys);
    ser_int_err <= 1'b0;
    wr32(dsl_pkg::OFF_STATUS, 32'h0000003F);
    wr32(dsl_pkg::OFF_MASK, 32'h00000001);
    @(posedge clk_sys);
    ser_link_err <= 1'b1;
    tk(2);
    chk(irq === 1'b0, "masked");
    @(posedge clk_sys);
    rio_comm_err <= 1'b1;
    tk(2);
    chk(irq === 1'b1, "irq");
    rd32(dsl_pkg::OFF_STATUS);
    chk(d === 32'h00000005, "status");
    wr32(dsl_pkg::OFF_STATUS, 32'h00000001);
    #1;
    chk(irq === 1'b0, "w1c");
    rd32(8'h40);
    chk(d === 32'h00000000, "unmapped");
    wr32(dsl_pkg::OFF_CONFIG, 32'h00000000);
    rd32(dsl_pkg::OFF_CONFIG);
    chk(d === cfg, "read only");
    wr32(dsl_pkg::OFF_CTRL, 32'h00000002);
    tk(1);
    chk(ser_comm_en === 1'b0, "serial off");
  endtask
  task t_flash;
    int k;
    k = 0;
    rst(8'h00, 8'h00, 2);
    @(posedge clk_sys);
    rio_test_code <= 3'h5;
    rio_test_done <= 1'b1;
    ser_test_code <= 3'h6;
    ser_test_done <= 1'b1;
    repeat (20) begin
      tk(1);
      k += int'(rio_activity_indicator === 1'b1);
      chk(!rio_ready_led && !rio_link_fault_indicator && rio_activity_indicator === rio_if_fault_led, "code");
      chk(!ser_ready_led && !ser_activity_indicator, "serial code");
      chk(ser_link_fault_indicator === rio_if_fault_led, "serial fault flash");
      chk(ser_int_fault_led === rio_if_fault_led, "serial internal flash");
    end
    chk(k > 5 && k < 15, "flash");
    rd32(dsl_pkg::OFF_STATUS);
    chk(d === 32'h00000030, "fail events");
  endtask
  task finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #40000;
    fails++;
    finish_test;
  end
  initial begin
    {rstn, rio_test_done, rio_comm_err, dual_port, ser_test_done, go} = 6'h00;
    {ser_char_busy, ser_link_err, ser_int_err, reg_wr, reg_rd} = 5'h00;
    {drop_sw, ser_sw, reg_addr, reg_wdata} = 56'h0;
    {rio_test_code, ser_test_code} = 6'h00;
    rio_carrier = 2'h1;
    rst(8'h00, 8'h00, 12);
    t_decode(5'h00, 4'h0, 3'h0);
    t_decode(5'h1F, 4'hF, 3'h7);
    t_decode(5'h01, 4'h5, 3'h2);
    t_leds;
    t_irq;
    t_flash;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
